// ==== rtl/fsp_pkg.sv ====
package fsp_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS           = 50;
  localparam int WP_FILTER_NS            = 200;
  localparam int WP_FILTER_CYC           = (WP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_PROTECT_ON_DELAY_NS  = 500;
  localparam int PIN_PROTECT_OFF_DELAY_NS = 500;
  localparam int PIN_PROTECT_ON_CYC      = PIN_PROTECT_ON_DELAY_NS / CLK_PERIOD_NS;
  localparam int PIN_PROTECT_OFF_CYC     = PIN_PROTECT_OFF_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [3:0] WP_FILTER_LAST  = 4'(WP_FILTER_CYC - 1);
  localparam logic [3:0] WP_FILTER_ZERO  = 4'h0;

  // command sequence bytes
  localparam logic [7:0] SEQ_BYTE0 = 8'h3D;
  localparam logic [7:0] SEQ_BYTE1 = 8'h2A;
  localparam logic [7:0] SEQ_BYTE2 = 8'h7F;
  localparam logic [7:0] SEQ_ENA   = 8'hA9;
  localparam logic [7:0] SEQ_DIS   = 8'h9A;
  localparam logic [2:0] SEQ_LEN   = 3'h4;
  localparam logic [2:0] BYTE_SAT  = 3'h5;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] CNT_ZERO  = 3'h0;

  // protection register layout
  localparam int         SECTOR_COUNT = 64;
  localparam int         SUB0A_HI     = 7;
  localparam int         SUB0A_LO     = 6;
  localparam int         SUB0B_HI     = 5;
  localparam int         SUB0B_LO     = 4;
  localparam logic [7:0] SPR_CLEAR    = 8'h00;
  localparam logic [1:0] SUB_CLEAR    = 2'h0;

  // reset values
  localparam logic SW_PROT_RESET = 1'b0;
  localparam logic WP_IDLE_LEVEL = 1'b1;

  typedef logic [SECTOR_COUNT-1:0][7:0] fsp_spr_type;

  typedef struct packed {
    logic sck;
    logic csN;
    logic mosi;
  } fsp_spi_type;

  localparam fsp_spi_type SPI_IDLE = '{sck: 1'b0, csN: 1'b1, mosi: 1'b0};

  typedef struct packed {
    logic       req;
    logic [5:0] sector;
    logic       subB;
    logic       sprTarget;
  } fsp_op_req_type;

  typedef struct packed {
    logic grant;
    logic deny;
  } fsp_op_resp_type;

  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_RECV,
    FSP_DISCARD
  } fsp_state_type;
endpackage

// ==== rtl/fsp_wp_filter.sv ====
`timescale 1ns/10ps
module fsp_wp_filter (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // raw pin, active low
  input  wire logic wpN,
  // filtered level, high while protection is forced
  output logic      wpAct
);
  import fsp_pkg::*;

  logic       wpS1;
  logic       wpS2;
  logic       wpS3;
  logic       wpLvl;
  logic [3:0] cnt;
  wire        agree   = (wpS2 == wpS3);
  wire        differs = agree && (wpS3 != wpLvl);
  wire        settle  = differs && (cnt == WP_FILTER_LAST);

  // synchroniser; idle level is high, as with the internal pull-up
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wpS1 <= WP_IDLE_LEVEL; // RL5
      wpS2 <= WP_IDLE_LEVEL;
      wpS3 <= WP_IDLE_LEVEL;
    end else begin
      wpS1 <= wpN;
      wpS2 <= wpS1;
      wpS3 <= wpS2;
    end
  end

  // a new level must hold for the whole filter time before it counts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wpLvl <= WP_IDLE_LEVEL;
      cnt   <= WP_FILTER_ZERO;
      wpAct <= 1'b0;
    end else begin
      cnt   <= (differs && !settle) ? cnt + 4'h1 : WP_FILTER_ZERO; // RL12
      wpLvl <= settle ? wpS3 : wpLvl;
      wpAct <= settle ? !wpS3 : wpAct;
    end
  end

  property p_filter_hold;
    @(posedge core_clk) disable iff (srst)
    !$stable(wpAct) |-> $past(cnt) == WP_FILTER_LAST;
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("wp level changed before filter time"); // RL12
endmodule

// ==== rtl/fsp_ctrl.sv ====
`timescale 1ns/10ps
// Function
// [RL1] enable sequence sets software protection
// [RL2] disable sequence clears software protection
// [RL3] change applies only at chip-select release
// [RL4] reset leaves software protection off
// [RL5] idle write-protect pin reads deasserted
// [RL6] asserted pin guards the protection register
// [RL7] asserting pin forces protection within delay
// [RL8] pin release drops pin-only protection
// [RL9] command-enabled protection survives pin release
// [RL10] disable ignored while pin asserted
// [RL11] pin only adds protection, never removes
// [RL12] pin glitches are filtered out
// [RL13] status bit shows protection enabled
// [RL14] only marked sectors are blocked
// [RL15] one mark byte per sector, sector 0 split
// [RL16] erased mark byte means protected
// [RL17] blocked operation discarded until chip-select release
module fsp_ctrl (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  // serial pins
  input  wire fsp_pkg::fsp_spi_type     spiPins,
  input  wire logic                     wpN,
  // protection register contents from the nonvolatile store
  input  wire fsp_pkg::fsp_spr_type     sprBytes,
  // program or erase request from the command core
  input  wire fsp_pkg::fsp_op_req_type  opReq,
  output fsp_pkg::fsp_op_resp_type      opResp,
  // status
  output logic                          protStatus,
  output logic                          sprWritable,
  output logic                          discarding
);
  import fsp_pkg::*;

  fsp_spi_type     spiS1;
  fsp_spi_type     spiS2;
  fsp_spi_type     spiS3;
  fsp_spi_type     spiF;
  fsp_spi_type     spiPrev;
  fsp_state_type   state;
  fsp_state_type   next_state;
  logic [7:0]      shiftReg;
  logic [2:0]      bitCnt;
  logic [2:0]      byteCnt;
  logic            matchEna;
  logic            matchDis;
  logic            swEn;
  logic            next_swEn;
  logic            wpAct;
  logic [SECTOR_COUNT-1:0] markA;
  logic [SECTOR_COUNT-1:0] markB;

  // write-protect pin filter
  fsp_wp_filter u_wp_filter (
    .core_clk (core_clk),
    .srst     (srst),
    .wpN      (wpN),
    .wpAct    (wpAct)
  );

  // three-stage synchronisers on the serial pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      spiS1 <= SPI_IDLE;
      spiS2 <= SPI_IDLE;
      spiS3 <= SPI_IDLE;
    end else begin
      spiS1 <= spiPins;
      spiS2 <= spiS1;
      spiS3 <= spiS2;
    end
  end

  // a pin change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      always_ff @(posedge core_clk) begin
        if (srst) begin
          spiF[gi]    <= SPI_IDLE[gi];
          spiPrev[gi] <= SPI_IDLE[gi];
        end else begin
          spiF[gi]    <= (spiS2[gi] == spiS3[gi]) ? spiS3[gi] : spiF[gi];
          spiPrev[gi] <= spiF[gi];
        end
      end
    end
  endgenerate

  // serial events
  wire       sckRise  = spiF.sck && !spiPrev.sck && !spiF.csN;
  wire       csFall   = !spiF.csN && spiPrev.csN;
  wire       csRise   = spiF.csN && !spiPrev.csN;
  wire [7:0] nextByte = {shiftReg[6:0], spiF.mosi};
  wire       byteDone = sckRise && (bitCnt == BIT_LAST);

  // expected byte at each position of the sequence
  wire prefixOk = (byteCnt == 3'h0 && nextByte == SEQ_BYTE0) ||
                  (byteCnt == 3'h1 && nextByte == SEQ_BYTE1) ||
                  (byteCnt == 3'h2 && nextByte == SEQ_BYTE2);
  wire lastEna  = (byteCnt == 3'h3) && (nextByte == SEQ_ENA);
  wire lastDis  = (byteCnt == 3'h3) && (nextByte == SEQ_DIS);

  // complete sequence: exactly four whole bytes before release
  wire seqDone = (byteCnt == SEQ_LEN) && (bitCnt == CNT_ZERO);
  wire enaCmd  = csRise && (state == FSP_RECV) && seqDone && matchEna; // RL3
  wire disCmd  = csRise && (state == FSP_RECV) && seqDone && matchDis && !wpAct; // RL10

  // receive shifter and byte matcher
  always_ff @(posedge core_clk) begin
    if (srst || csFall) begin
      shiftReg <= SPR_CLEAR;
      bitCnt   <= CNT_ZERO;
      byteCnt  <= CNT_ZERO;
      matchEna <= 1'b1;
      matchDis <= 1'b1;
    end else if (sckRise) begin
      shiftReg <= nextByte;
      bitCnt   <= bitCnt + 3'h1;
      if (byteDone) begin
        byteCnt  <= (byteCnt == BYTE_SAT) ? BYTE_SAT : byteCnt + 3'h1;
        matchEna <= matchEna && (prefixOk || lastEna);
        matchDis <= matchDis && (prefixOk || lastDis);
      end
    end
  end

  // software protection state
  always_comb begin
    next_swEn = swEn; // RL9
    if (enaCmd) begin
      next_swEn = 1'b1; // RL1
    end else if (disCmd) begin
      next_swEn = 1'b0; // RL2
    end
  end

  // command state
  always_comb begin
    next_state = state;
    case (state)
      FSP_IDLE: begin
        if (csFall) next_state = FSP_RECV;
      end
      FSP_RECV: begin
        if (csRise) next_state = FSP_IDLE;
        else if (opResp.deny) next_state = FSP_DISCARD; // RL17
      end
      FSP_DISCARD: begin
        if (csRise) next_state = FSP_IDLE; // RL17
      end
      default: next_state = FSP_IDLE;
    endcase
  end

  // per-sector marks; sector 0 carries two half fields
  generate
    for (gi = 0; gi < SECTOR_COUNT; gi++) begin : g_mark
      if (gi == 0) begin : g_split
        assign markA[gi] = sprBytes[gi][SUB0A_HI:SUB0A_LO] != SUB_CLEAR; // RL15
        assign markB[gi] = sprBytes[gi][SUB0B_HI:SUB0B_LO] != SUB_CLEAR; // RL15
      end else begin : g_whole
        assign markA[gi] = sprBytes[gi] != SPR_CLEAR; // RL16
        assign markB[gi] = sprBytes[gi] != SPR_CLEAR;
      end
    end
  endgenerate

  // operation check
  wire sectorMarked = opReq.subB ? markB[opReq.sector] : markA[opReq.sector];
  wire sprBlocked   = opReq.sprTarget && wpAct; // RL6
  wire arrBlocked   = !opReq.sprTarget && protStatus && sectorMarked; // RL14
  wire opBlocked    = sprBlocked || arrBlocked;

  // registers and outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state       <= FSP_IDLE;
      swEn        <= SW_PROT_RESET; // RL4
      protStatus  <= SW_PROT_RESET;
      sprWritable <= 1'b1;
      discarding  <= 1'b0;
      opResp      <= '0;
    end else begin
      state       <= next_state;
      swEn        <= next_swEn;
      protStatus  <= next_swEn || wpAct; // RL7 RL8 RL11 RL13
      sprWritable <= !wpAct; // RL6
      discarding  <= (next_state == FSP_DISCARD);
      opResp      <= '{grant: opReq.req && !opBlocked, deny: opReq.req && opBlocked}; // RL17
    end
  end

  // checks
  localparam int ON_MAX  = PIN_PROTECT_ON_CYC;
  localparam int OFF_MAX = PIN_PROTECT_OFF_CYC;

  property p_ena_sets;
    @(posedge core_clk) disable iff (srst)
    enaCmd |=> swEn && protStatus;
  endproperty
  a_ena_sets: assert property (p_ena_sets) else $error("enable sequence did not set protection"); // RL1

  property p_dis_clears;
    @(posedge core_clk) disable iff (srst)
    disCmd && !enaCmd |=> !swEn;
  endproperty
  a_dis_clears: assert property (p_dis_clears) else $error("disable sequence did not clear"); // RL2

  property p_cs_only;
    @(posedge core_clk) disable iff (srst)
    !$stable(swEn) |-> $past(csRise) && $past(state) == FSP_RECV;
  endproperty
  a_cs_only: assert property (p_cs_only) else $error("software state changed without release"); // RL3

  property p_reset_off;
    @(posedge core_clk)
    srst |=> !swEn && !protStatus;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("protection on after reset"); // RL4

  property p_pin_forces;
    @(posedge core_clk) disable iff (srst)
    $fell(wpN) ##1 !wpN [*7] |-> ##[0:ON_MAX] protStatus;
  endproperty
  a_pin_forces: assert property (p_pin_forces) else $error("pin did not force protection"); // RL7

  property p_pin_release;
    @(posedge core_clk) disable iff (srst)
    !wpAct && !swEn && !enaCmd |=> !protStatus;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("protection kept after pin release"); // RL8

  property p_keep;
    @(posedge core_clk) disable iff (srst)
    $fell(wpAct) && swEn && !disCmd |-> ##1 protStatus;
  endproperty
  a_keep: assert property (p_keep) else $error("command protection lost at pin release"); // RL9

  property p_dis_ignored;
    @(posedge core_clk) disable iff (srst)
    wpAct && swEn |=> swEn;
  endproperty
  a_dis_ignored: assert property (p_dis_ignored) else $error("disable accepted with pin asserted"); // RL10

  property p_status;
    @(posedge core_clk) disable iff (srst)
    protStatus |-> swEn || $past(wpAct);
  endproperty
  a_status: assert property (p_status) else $error("status bit set with no cause"); // RL13

  property p_marked_deny;
    @(posedge core_clk) disable iff (srst)
    opReq.req && !opReq.sprTarget && protStatus && sectorMarked |=> opResp.deny && !opResp.grant;
  endproperty
  a_marked_deny: assert property (p_marked_deny) else $error("marked sector not blocked"); // RL14

  property p_spr_guard;
    @(posedge core_clk) disable iff (srst)
    opReq.req && opReq.sprTarget && wpAct |=> opResp.deny;
  endproperty
  a_spr_guard: assert property (p_spr_guard) else $error("register change allowed with pin asserted"); // RL6

  property p_discard;
    @(posedge core_clk) disable iff (srst)
    state == FSP_DISCARD && !csRise |=> state == FSP_DISCARD;
  endproperty
  a_discard: assert property (p_discard) else $error("left discard before release"); // RL17

  // pin-only protection must be gone within the release delay
  property p_pin_drop;
    @(posedge core_clk) disable iff (srst)
    $rose(wpN) ##1 wpN [*7] |-> ##[0:OFF_MAX] (!protStatus || swEn);
  endproperty
  a_pin_drop: assert property (p_pin_drop) else $error("pin protection not dropped in time"); // RL8

  property p_spr_open;
    @(posedge core_clk) disable iff (srst)
    opReq.req && opReq.sprTarget && !wpAct |=> opResp.grant && !opResp.deny;
  endproperty
  a_spr_open: assert property (p_spr_open) else $error("register change refused with pin released"); // RL6

  property p_unmarked_grant;
    @(posedge core_clk) disable iff (srst)
    opReq.req && !opReq.sprTarget && (!protStatus || !sectorMarked) |=> opResp.grant && !opResp.deny;
  endproperty
  a_unmarked_grant: assert property (p_unmarked_grant) else $error("unprotected sector blocked"); // RL14

  property p_discard_entry;
    @(posedge core_clk) disable iff (srst)
    state == FSP_RECV && opResp.deny && !csRise |=> discarding;
  endproperty
  a_discard_entry: assert property (p_discard_entry) else $error("refused op inside frame not discarded"); // RL17

  c_enable:  cover property (@(posedge core_clk) disable iff (srst) enaCmd);
  c_disable: cover property (@(posedge core_clk) disable iff (srst) disCmd);
  c_deny:    cover property (@(posedge core_clk) disable iff (srst) opResp.deny ##[1:50] csRise);
  c_pin_on:  cover property (@(posedge core_clk) disable iff (srst) $rose(wpAct) && !swEn);
  c_keep:    cover property (@(posedge core_clk) disable iff (srst) $fell(wpAct) && swEn);
endmodule

// ==== dv/fsp_spi_host.sv ====
`timescale 1ns/10ps
module fsp_spi_host (
  // clock
  input  wire logic          core_clk,
  // serial pins towards the device
  output fsp_pkg::fsp_spi_type spiPins
);
  import fsp_pkg::*;

  // idle pins at time zero
  initial begin
    spiPins = SPI_IDLE;
  end

  // data line is not held between frames: it toggles so a stale bit cannot be mistaken
  always @(negedge core_clk) begin
    if (spiPins.csN) begin
      spiPins.mosi <= ~spiPins.mosi;
    end
  end

  // select, then nbits bits MSB first, each sck level held 4 cycles; sck idles low
  task automatic shift(input logic [39:0] word, input int nbits);
    @(negedge core_clk);
    spiPins.csN = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      spiPins.mosi = word[i];
      repeat (4) @(negedge core_clk);
      spiPins.sck = 1'b1;
      repeat (4) @(negedge core_clk);
      spiPins.sck = 1'b0;
    end
  endtask

  // deselect after the last bit and keep the gap before any next frame
  task automatic endFrame();
    repeat (4) @(negedge core_clk);
    spiPins.csN = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// ==== dv/fsp_ctrl_tb_top.sv ====
`timescale 1ns/10ps
module fsp_ctrl_tb_top;
  import fsp_pkg::*;

  logic            core_clk;
  logic            srst;
  fsp_spi_type     spiPins;
  logic            wpN;
  fsp_spr_type     sprBytes;
  fsp_op_req_type  opReq;
  fsp_op_resp_type opResp;
  logic            protStatus;
  logic            sprWritable;
  logic            discarding;
  int              errors;
  int              samples_checked;
  int              cycles;
  integer          seed;
  logic            expSw;
  logic            wpExp;
  logic [7:0]      expQ[$];

  fsp_spi_host host (.core_clk(core_clk), .spiPins(spiPins));

  fsp_ctrl dut (.core_clk(core_clk), .srst(srst), .spiPins(spiPins), .wpN(wpN), .sprBytes(sprBytes),
    .opReq(opReq), .opResp(opResp), .protStatus(protStatus), .sprWritable(sprWritable),
    .discarding(discarding));

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic test_done();
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      test_done();
    end
  end

  // response watcher takes the oldest note for every grant or deny pulse
  always @(negedge core_clk) begin
    if ((opResp.grant | opResp.deny) === 1'b1) begin
      if (expQ.size() == 0) check("opResp_unexpected", 8'h01, 8'h00);
      else check("opResp", {6'h00, opResp}, expQ.pop_front());
    end
  end

  // one request cycle, with its expected answer noted from the marks and the protection state
  task automatic op(input logic [5:0] sec, input logic sb, input logic spr);
    logic [7:0] b;
    logic       marked;
    logic       d;
    b = sprBytes[sec];
    marked = (sec == 6'h00) ? (sb ? |b[5:4] : |b[7:6]) : |b;
    d = spr ? wpExp : ((expSw | wpExp) & marked);
    expQ.push_back({6'h00, ~d, d});
    opReq = '{req: 1'b1, sector: sec, subB: sb, sprTarget: spr};
    @(negedge core_clk);
  endtask

  // back-to-back random requests plus both halves of sector 0
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) op(6'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    op(6'h00, 1'b0, 1'b0);
    op(6'h00, 1'b1, 1'b0);
    opReq.req = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic waitProt(input logic exp, input int lim);
    int n;
    n = 0;
    while (protStatus !== exp && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check("protStatus", protStatus, exp);
  endtask

  task automatic stay(input logic exp, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (protStatus !== exp) bad++;
    end
    check("protStatus_steady", bad == 0, 1'b1);
  endtask

  task automatic frame(input logic [31:0] word);
    host.shift({8'h00, word}, 32);
    host.endFrame();
  endtask

  initial begin
    errors = 0; samples_checked = 0; cycles = 0; seed = 32'h8730;
    srst = 1'b1; wpN = 1'b1; opReq = '0; expSw = 1'b0; wpExp = 1'b0;
    for (int s = 0; s < SECTOR_COUNT; s++) sprBytes[s] = $random(seed) & 1 ? 8'hFF : 8'h00;
    sprBytes[0] = 8'hC0;
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    repeat (6) @(negedge core_clk);
    check("protStatus", protStatus, 1'b0);
    check("sprWritable", sprWritable, 1'b1);
    check("discarding", discarding, 1'b0);
    burst(8);
    host.shift(40'h003D2A7FA9, 32);
    stay(1'b0, 12);
    host.endFrame();
    expSw = 1'b1;
    waitProt(1'b1, 12);
    burst(16);
    for (int s = 0; s < SECTOR_COUNT; s++) sprBytes[s] = 8'hFF;
    burst(8);
    // short, long and foreign frames leave the state alone
    for (int i = 0; i < 3; i++) begin
      host.shift(i == 0 ? 40'h001E953FCD : i == 1 ? 40'h007A54FF34 : 40'h003D2A7FCF, i == 0 ? 31 : i == 1 ? 33 : 32);
      host.endFrame();
      stay(1'b1, 8);
    end
    frame(32'h3D2A7F9A);
    expSw = 1'b0;
    waitProt(1'b0, 12);
    wpN = 1'b0;
    repeat (2) @(negedge core_clk);
    wpN = 1'b1;
    stay(1'b0, 14);
    wpN = 1'b0;
    wpExp = 1'b1;
    waitProt(1'b1, 10);
    check("sprWritable", sprWritable, 1'b0);
    burst(8);
    wpN = 1'b1;
    repeat (2) @(negedge core_clk);
    wpN = 1'b0;
    stay(1'b1, 14);
    frame(32'h3D2A7F9A);
    stay(1'b1, 14);
    wpN = 1'b1;
    wpExp = 1'b0;
    waitProt(1'b0, 10);
    check("sprWritable", sprWritable, 1'b1);
    wpN = 1'b0;
    wpExp = 1'b1;
    waitProt(1'b1, 10);
    frame(32'h3D2A7FA9);
    expSw = 1'b1;
    wpN = 1'b1;
    wpExp = 1'b0;
    stay(1'b1, 14);
    frame(32'h3D2A7F9A);
    expSw = 1'b0;
    waitProt(1'b0, 12);
    frame(32'h3D2A7FA9);
    expSw = 1'b1;
    waitProt(1'b1, 12);
    // refused request inside an open frame
    host.shift(40'h003D2A7F9A, 16);
    op(6'h05, 1'b0, 1'b0);
    opReq.req = 1'b0;
    @(negedge core_clk);
    check("discarding", discarding, 1'b1);
    host.shift(40'h00000000FF, 8);
    host.endFrame();
    check("discarding", discarding, 1'b0);
    stay(1'b1, 4);
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    expSw = 1'b0;
    repeat (6) @(negedge core_clk);
    check("protStatus", protStatus, 1'b0);
    check("pending", 8'(expQ.size()), 8'h00);
    test_done();
  end
endmodule
